// [design/otp_params.svh]
// Purpose: constants of the subcarrier test pattern source
// Assumes: included by the package and the design modules
// Notes:   definitions only
`ifndef OTP_PARAMS_SVH
`define OTP_PARAMS_SVH

// real word layout
`define OTP_SYM_LO     14
`define OTP_SYM_W      2
`define OTP_CLS_LO     12
`define OTP_CLS_W      2
`define OTP_ORD_W      12
`define OTP_SYM_FIRST  2'h0
`define OTP_SYM_LAST   2'h2

// carrier class codes
`define OTP_CLS_USE    2'h0
`define OTP_CLS_LEFT   2'h1
`define OTP_CLS_RIGHT  2'h2
`define OTP_CLS_DC     2'h3
`define OTP_DC_CODE    14'h3000

// half of the usable carriers per fft size
`define OTP_HALF_128   48
`define OTP_HALF_512   204
`define OTP_HALF_1024  420
`define OTP_HALF_2048  840
`define OTP_FFT_DEF    1024

// register byte offsets
`define OTP_ADDR_W     8
`define OTP_A_CTRL     8'h00
`define OTP_A_STAT     8'h04
`define OTP_A_DMAP     8'h08
`define OTP_A_RMAP     8'h0C
`define OTP_A_GRP      8'h10

// register fields and reset values
`define OTP_CTRL_EN    0
`define OTP_CTRL_RST   1'b1
`define OTP_ST_RUN     0
`define OTP_ST_VLD     1
`define OTP_ST_SYM_LO  4
`define OTP_ST_BIN_LO  16
`define OTP_MAP_RST    32'h0000_0000
`define OTP_GRP_RST    16'h0000
`define OTP_IMAG_RST   16'h0000
`define OTP_IMAG_STEP  16'h0001

`endif

// [design/otp_pkg.sv]
// Purpose: types of the subcarrier test pattern source
// Assumes: otp_params.svh on the include path
// Notes:   state codes follow a gray order
`include "otp_params.svh"

package otp_pkg;

	// generator states
	typedef enum logic [0:0] {
		OTP_IDLE = 1'b0,
		OTP_RUN  = 1'b1
	} otp_state_t;

	// carrier classes
	typedef enum logic [1:0] {
		OTP_USE   = `OTP_CLS_USE,
		OTP_LEFT  = `OTP_CLS_LEFT,
		OTP_RIGHT = `OTP_CLS_RIGHT,
		OTP_DC    = `OTP_CLS_DC
	} otp_cls_t;

endpackage : otp_pkg

// [design/otp_cfg_src.sv]
// Purpose: resends one fixed configuration word on request
// Assumes: sink takes a word when valid and ready are both high
// Notes:   the same word is offered again after every take
`include "otp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module otp_cfg_src
	import otp_pkg::*;
#(
	parameter int W = 32
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// control side
	input  wire logic         en,
	input  wire logic [W-1:0] word,
	// sink side
	input  wire logic         cfg_ready,
	output logic              cfg_valid,
	output logic [W-1:0]      cfg_data
);

	// whole state of the source
	typedef struct packed {
		logic         vld;   // word on offer
		logic [W-1:0] data;  // offered word
	} otp_cfg_st_t;

	otp_cfg_st_t r;    // registered state
	otp_cfg_st_t nxt;  // next state

	// reload the same word once the slot is free
	always_comb begin
		nxt = r;
		if (!r.vld || cfg_ready) begin  // see R13
			nxt.vld  = en;
			nxt.data = word;
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign cfg_valid = r.vld;
	assign cfg_data  = r.data;

endmodule : otp_cfg_src

`default_nettype wire

// [design/otp_top.sv]
// Purpose: frequency domain test pattern source for desubchannelization
// Assumes: one clock, downstream takes a sample on valid and ready
// Notes:   registers over ahb-lite, config maps resent on request
// Contract
// R1 - real word: symbol, class, ordinal fields
// R2 - symbol field 00, 01, 10 in group
// R3 - class codes usable, left, right, dc
// R4 - ordinal counts per class, dc zero
// R5 - distinct values per group, repeating
// R6 - bins from dc up, then negatives
// R7 - usable from lowest negative, guards outside
// R8 - sink takes groups of three, dc first
// R9 - sink slots hold 72 tagged samples
// R10 - ranging packets 144, or 96 small fft
// R11 - ranging samples low to high carrier
// R12 - imaginary part from free running counter
// R13 - resend same data and ranging maps
// R14 - advance on accept, wrap after third
// R15 - fft size fixed at build time
`include "otp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module otp_top
	import otp_pkg::*;
#(
	parameter int          FFT_SIZE  = `OTP_FFT_DEF,  // see R15
	parameter logic [31:0] DMAP_INIT = `OTP_MAP_RST,
	parameter logic [31:0] RMAP_INIT = `OTP_MAP_RST
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// symbol stream
	input  wire logic        din_ready,
	output logic             din_valid,
	output logic             din_sop,
	output logic [15:0]      din_real,
	output logic [15:0]      din_imag,
	// user data map
	input  wire logic        dmap_ready,
	output logic             dmap_valid,
	output logic [31:0]      dmap_data,
	// ranging map
	input  wire logic        rmap_ready,
	output logic             rmap_valid,
	output logic [31:0]      rmap_data
);

	// half of the usable carriers for a size
	function automatic int otp_half(input int n);
		case (n)
			128:     return `OTP_HALF_128;
			512:     return `OTP_HALF_512;
			2048:    return `OTP_HALF_2048;
			default: return `OTP_HALF_1024;
		endcase
	endfunction : otp_half

	localparam int HALF   = otp_half(FFT_SIZE);       // see R15
	localparam int LEFT_N = FFT_SIZE / 2 - HALF;      // left guards
	localparam int BW     = $clog2(FFT_SIZE);
	localparam logic [BW-1:0] BIN_LAST = BW'(FFT_SIZE - 1);

	// carrier code of bin slot k, k counted from dc upward
	function automatic logic [13:0] otp_code(input logic [BW-1:0] k);
		int ki;
		logic [1:0]  c;
		logic [11:0] o;
		ki = int'(k);
		if (ki == 0) begin                       // see R4
			c = `OTP_CLS_DC;
			o = '0;
		end else if (ki <= HALF) begin           // see R7
			c = `OTP_CLS_USE;
			o = 12'(HALF - 1 + ki);
		end else if (ki < FFT_SIZE / 2) begin    // see R7
			c = `OTP_CLS_RIGHT;
			o = 12'(ki - HALF - 1);
		end else if (ki < FFT_SIZE - HALF) begin // see R7
			c = `OTP_CLS_LEFT;
			o = 12'(ki - FFT_SIZE / 2);
		end else begin                           // see R7
			c = `OTP_CLS_USE;
			o = 12'(ki - (FFT_SIZE - HALF));
		end
		return {c, o};                           // see R3
	endfunction : otp_code

	// whole state of the block
	typedef struct packed {
		otp_state_t                st;    // generator state
		logic                      en;    // control enable
		logic [BW-1:0]             bin;   // next bin slot
		logic [1:0]                sym;   // symbol in group
		logic [15:0]               imag;  // free running count
		logic                      vld;   // sample on offer
		logic                      sop;   // sample is dc bin
		logic [15:0]               re;    // offered real word
		logic [31:0]               dmap;  // user data map word
		logic [31:0]               rmap;  // ranging map word
		logic [15:0]               grp;   // groups sent
		logic                      aw;    // write data phase due
		logic [`OTP_ADDR_W-1:0]    wa;    // write address
		logic [31:0]               rdata; // read data
		logic                      rdy;   // hreadyout
	} otp_st_t;

	otp_st_t r;    // registered state
	otp_st_t nxt;  // next state
	logic    take; // sample accepted this cycle
	logic    sel;  // ahb address phase for us

	assign take = r.vld && din_ready;
	assign sel  = hsel && hready && htrans[1];

	// next state: bus, generator, counter
	always_comb begin
		nxt      = r;
		nxt.rdy  = 1'b1;
		nxt.aw   = 1'b0;
		nxt.imag = r.imag + `OTP_IMAG_STEP;  // see R12
		// write data phase
		if (r.aw) begin
			case (r.wa)
				`OTP_A_CTRL: nxt.en   = hwdata[`OTP_CTRL_EN];
				`OTP_A_DMAP: nxt.dmap = hwdata;
				`OTP_A_RMAP: nxt.rmap = hwdata;
				default:     ;  // unmapped or read only
			endcase
		end
		// drop the offered sample once taken
		if (take) begin
			nxt.vld = 1'b0;
		end
		case (r.st)
			OTP_IDLE: begin
				// idle restarts the group at dc
				nxt.bin = '0;
				nxt.sym = `OTP_SYM_FIRST;
				if (r.en) begin
					nxt.st = OTP_RUN;
				end
			end
			OTP_RUN: begin
				if (!r.vld || take) begin  // see R14
					if (!r.en) begin
						nxt.st = OTP_IDLE;
					end else begin
						nxt.vld = 1'b1;
						nxt.sop = (r.bin == '0);
						nxt.re  = {r.sym, otp_code(r.bin)};  // see R1
						if (r.bin == BIN_LAST) begin  // see R6
							nxt.bin = '0;
							if (r.sym == `OTP_SYM_LAST) begin  // see R2
								nxt.sym = `OTP_SYM_FIRST;  // see R5
								nxt.grp = r.grp + 16'h0001;
							end else begin
								nxt.sym = r.sym + 2'h1;
							end
						end else begin
							nxt.bin = r.bin + BW'(1);  // see R6
						end
					end
				end
			end
			default: nxt.st = OTP_IDLE;
		endcase
		// address phase, reads see this cycle's write
		if (sel) begin
			if (hwrite) begin
				nxt.aw = 1'b1;
				nxt.wa = haddr[`OTP_ADDR_W-1:0];
			end else begin
				nxt.rdata = '0;
				case (haddr[`OTP_ADDR_W-1:0])
					`OTP_A_CTRL: nxt.rdata[`OTP_CTRL_EN] = nxt.en;
					`OTP_A_STAT: begin
						nxt.rdata[`OTP_ST_RUN] = (r.st == OTP_RUN);
						nxt.rdata[`OTP_ST_VLD] = r.vld;
						nxt.rdata[`OTP_ST_SYM_LO +: 2] = r.sym;
						nxt.rdata[`OTP_ST_BIN_LO +: BW] = r.bin;
					end
					`OTP_A_DMAP: nxt.rdata = nxt.dmap;
					`OTP_A_RMAP: nxt.rdata = nxt.rmap;
					`OTP_A_GRP:  nxt.rdata[15:0] = r.grp;
					default:     nxt.rdata = '0;  // unmapped
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			r      <= '0;
			r.st   <= OTP_IDLE;
			r.en   <= `OTP_CTRL_RST;
			r.dmap <= DMAP_INIT;
			r.rmap <= RMAP_INIT;
			r.grp  <= `OTP_GRP_RST;
			r.imag <= `OTP_IMAG_RST;
			r.rdy  <= 1'b1;
		end else begin
			r <= nxt;
		end
	end

	// outputs straight from the state, hresp tied low
	assign hreadyout = r.rdy;
	assign hrdata    = r.rdata;
	assign hresp     = 1'b0;
	assign din_valid = r.vld;
	assign din_sop   = r.sop;
	assign din_real  = r.re;
	assign din_imag  = r.imag;

	// map sources, resent on every request
	otp_cfg_src #(.W(32)) u_dmap (  // see R13
		.hclk      (hclk),
		.hresetn   (hresetn),
		.en        (r.en),
		.word      (r.dmap),
		.cfg_ready (dmap_ready),
		.cfg_valid (dmap_valid),
		.cfg_data  (dmap_data)
	);
	otp_cfg_src #(.W(32)) u_rmap (  // see R13
		.hclk      (hclk),
		.hresetn   (hresetn),
		.en        (r.en),
		.word      (r.rmap),
		.cfg_ready (rmap_ready),
		.cfg_valid (rmap_valid),
		.cfg_data  (rmap_data)
	);

	// checking helpers: last taken word, takes since dc
	logic [15:0] prev_re;
	logic        prev_ok;
	int          since;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev_re <= '0;
			prev_ok <= 1'b0;
			since   <= 0;
		end else if (r.st == OTP_IDLE) begin
			// a restart begins a fresh group, forget the old one
			prev_ok <= 1'b0;
		end else if (take) begin
			prev_re <= din_real;
			prev_ok <= 1'b1;
			since   <= din_sop ? 1 : since + 1;
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_code_dc: assert property (din_valid && din_sop |->  // see R1
		din_real[13:0] == `OTP_DC_CODE)
		else $error("dc sample code wrong");
	a_sym_range: assert property (din_valid |->  // see R2
		din_real[15:14] <= `OTP_SYM_LAST)
		else $error("symbol index out of range");
	a_dc_only_sop: assert property (din_valid |->  // see R3
		((din_real[13:12] == `OTP_CLS_DC) == din_sop))
		else $error("dc class off the dc bin");
	a_dc_ordinal: assert property (din_valid && din_sop |->  // see R4
		din_real[11:0] == '0)
		else $error("dc ordinal not zero");
	a_taken_distinct: assert property (take && prev_ok |->  // see R5
		din_real != prev_re)
		else $error("repeated value inside a symbol");
	a_sop_period: assert property (take && din_sop && prev_ok |->  // see R6
		since == FFT_SIZE)
		else $error("symbol length wrong");
	a_usable_top: assert property (take && prev_ok &&  // see R7
		din_real[13:0] == {`OTP_CLS_RIGHT, 12'h000} |->
		prev_re[13:0] == {`OTP_CLS_USE, 12'(2 * HALF - 1)})
		else $error("right guard not after top usable");
	a_left_count: assert property (din_valid &&  // see R15
		din_real[13:12] == `OTP_CLS_LEFT |-> din_real[11:0] < LEFT_N)
		else $error("left guard ordinal too large");
	a_imag_count: assert property ($past(hresetn) |->  // see R12
		din_imag == $past(din_imag) + `OTP_IMAG_STEP)
		else $error("imaginary counter skipped");
	a_hold_sample: assert property (din_valid && !din_ready |=>  // see R14
		din_valid && $stable(din_real) && $stable(din_sop))
		else $error("sample changed before accept");
	a_sym_wrap: assert property (take && din_sop && prev_ok &&  // see R14
		din_real[15:14] == `OTP_SYM_FIRST |->
		prev_re[15:14] == `OTP_SYM_LAST)
		else $error("group did not wrap after third");
	a_map_resend: assert property (dmap_valid && dmap_ready && r.en |=>  // see R13
		dmap_valid && dmap_data == $past(r.dmap))
		else $error("data map not resent");

	c_dc_taken: cover property (take && din_sop);
	c_third_sym: cover property (take && din_sop &&
		din_real[15:14] == `OTP_SYM_LAST);
	c_stall: cover property (din_valid && !din_ready [*2] ##1 take);
	c_maps: cover property (dmap_valid && dmap_ready ##1
		rmap_valid && rmap_ready);

endmodule : otp_top

`default_nettype wire

// [bench/otp_sink_model.sv]
// Purpose: downstream sink model taking samples and map words
// Assumes: stall set by the bench, changed just after an edge
// Notes:   when stalling, ready drops two cycles in four;
//          gathers slot and ranging packet figures by ordinal
`include "otp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module otp_sink_model #(
	parameter int FFT_SIZE = 1024  // fft size of the stream
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// control
	input  wire logic        stall,
	// stream watched
	input  wire logic        din_valid,
	input  wire logic        din_sop,
	input  wire logic [15:0] din_real,
	// ready outputs
	output logic             din_ready,
	output logic             dmap_ready,
	output logic             rmap_ready,
	// figures of the last closed slot and ranging packet
	output logic [15:0]      slot_len,
	output logic [15:0]      slot_sym_sum,
	output logic [15:0]      slot_tile_sum,
	output logic [15:0]      rng_len,
	output logic             rng_bad
);
	// one subchannel in one symbol: six tiles of four carriers
	localparam int SUB_N = 24;
	// ranging channel: four subchannels at 128, six otherwise
	localparam int RNG_N = (FFT_SIZE == 128) ? 96 : 144;

	logic [1:0]  ph_r;     // stall phase
	logic        tk;       // sample taken
	logic        use_c;    // taken sample is a usable carrier
	logic [11:0] ord;      // ordinal of the taken sample
	logic [15:0] s_n_r;    // slot samples in this group
	logic [15:0] s_sym_r;  // sum of symbol offset tags
	logic [15:0] s_tile_r; // sum of tile index tags
	logic [15:0] r_n_r;    // ranging samples in this symbol

	assign tk    = din_valid && din_ready;
	assign use_c = (din_real[13:12] == `OTP_CLS_USE);
	assign ord   = din_real[11:0];

	// slot of subchannel zero and ranging packet, closed at dc
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_n_r         <= '0;
			s_sym_r       <= '0;
			s_tile_r      <= '0;
			r_n_r         <= '0;
			slot_len      <= '0;
			slot_sym_sum  <= '0;
			slot_tile_sum <= '0;
			rng_len       <= '0;
			rng_bad       <= 1'b0;
		end else if (tk) begin
			if (din_sop) begin
				// every symbol start closes a ranging packet
				rng_len <= r_n_r;
				r_n_r   <= '0;
				if (din_real[15:14] == `OTP_SYM_FIRST) begin
					// every group start closes a slot
					slot_len      <= s_n_r;
					slot_sym_sum  <= s_sym_r;
					slot_tile_sum <= s_tile_r;
					s_n_r         <= '0;
					s_sym_r       <= '0;
					s_tile_r      <= '0;
				end
			end else if (use_c) begin
				if (ord < RNG_N) begin
					// ranging carriers must come lowest first
					rng_bad <= rng_bad || (ord != r_n_r[11:0]);
					r_n_r   <= r_n_r + 16'h0001;
				end
				if (ord < SUB_N) begin
					// tag: symbol offset and tile index
					s_n_r    <= s_n_r + 16'h0001;
					s_sym_r  <= s_sym_r + {14'h0000, din_real[15:14]};
					s_tile_r <= s_tile_r + {6'h00, ord[11:2]};
				end
			end
		end
	end

	// phase counter, advances every cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r <= 2'h0;
		end else begin
			ph_r <= ph_r + 2'h1;
		end
	end

	// takes samples in arrival order, dc bin first
	assign din_ready  = !(stall && ph_r[1]);
	// map words wanted on alternate cycles
	assign dmap_ready = ph_r[0];
	assign rmap_ready = !ph_r[0];
endmodule : otp_sink_model

`default_nettype wire

// [bench/tb_top.sv]
// Purpose: self-checking bench of the subcarrier pattern source
// Assumes: fft size 1024, zero wait ahb slave
// Notes:   expected words are derived from bin number and symbol
`include "otp_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam int N = 1024;           // fft size under test
	localparam int H = `OTP_HALF_1024; // usable carriers per half
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, dmap_data, rmap_data;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        din_ready, din_valid, din_sop, stall;
	logic [15:0] din_real, din_imag;
	logic        dmap_ready, dmap_valid, rmap_ready, rmap_valid;
	int          bad_count, cmp_count;
	logic [15:0] slot_len, slot_sym_sum, slot_tile_sum, rng_len;
	logic        rng_bad;

	assign hready = hreadyout;

	otp_top #(.FFT_SIZE(N)) otp_top_i (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.din_ready(din_ready), .din_valid(din_valid), .din_sop(din_sop),
		.din_real(din_real), .din_imag(din_imag),
		.dmap_ready(dmap_ready), .dmap_valid(dmap_valid),
		.dmap_data(dmap_data), .rmap_ready(rmap_ready),
		.rmap_valid(rmap_valid), .rmap_data(rmap_data));

	otp_sink_model #(.FFT_SIZE(N)) otp_sink_model_i (.hclk(hclk),
		.hresetn(hresetn), .stall(stall), .din_valid(din_valid),
		.din_sop(din_sop), .din_real(din_real), .din_ready(din_ready),
		.dmap_ready(dmap_ready), .rmap_ready(rmap_ready),
		.slot_len(slot_len), .slot_sym_sum(slot_sym_sum),
		.slot_tile_sum(slot_tile_sum), .rng_len(rng_len),
		.rng_bad(rng_bad));

	// 100 MHz clock
	always begin
		#5 hclk = ~hclk;
	end

	// compare and count
	task automatic chk(input string what, input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one single ahb transfer, waits on hready
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// expected real word for symbol s, sample k
	function automatic logic [15:0] exp_real(input int s, input int k);
		int b, o;
		logic [1:0] c;
		b = (k < N / 2) ? k : k - N;
		if (b == 0) begin
			c = 2'h3; o = 0;
		end else if (b > H) begin
			c = 2'h2; o = b - H - 1;
		end else if (b < -H) begin
			c = 2'h1; o = b + N / 2;
		end else begin
			c = 2'h0; o = (b > 0) ? b + H - 1 : b + H;
		end
		return {s[1:0], c, o[11:0]};
	endfunction : exp_real

	// reset values, unmapped place, write then read
	task automatic t_regs;
		logic [31:0] d;
		ahb(1'b0, `OTP_A_CTRL, 32'h0, d);
		chk("ctrl", d, 32'h0000_0001);
		ahb(1'b0, `OTP_A_RMAP, 32'h0, d);
		chk("rmap", d, `OTP_MAP_RST);
		ahb(1'b1, 8'h20, 32'hFFFF_FFFF, d);
		ahb(1'b0, 8'h20, 32'h0, d);
		chk("unmapped", d, 32'h0);
		chk("hresp", {31'h0, hresp}, 32'h0);
		chk("hready", {31'h0, hreadyout}, 32'h1);
		$display("test regs done");
	endtask : t_regs

	// disable, restart, then a group of three plus one
	task automatic t_stream;
		logic [31:0] d;
		logic [15:0] prev;
		int k;
		ahb(1'b1, `OTP_A_CTRL, 32'h0, d);
		repeat (4) @(posedge hclk);
		chk("valid off", {31'h0, din_valid}, 32'h0);
		ahb(1'b0, `OTP_A_STAT, 32'h0, d);
		chk("running", {31'h0, d[0]}, 32'h0);
		stall <= 1'b1;
		ahb(1'b1, `OTP_A_CTRL, 32'h1, d);
		k = 0;
		prev = din_imag;
		while (k <= 3 * N) begin
			@(posedge hclk);
			chk("imag", din_imag, 16'(prev + 16'h0001));
			prev = din_imag;
			if (din_valid === 1'b1 && din_ready === 1'b1) begin
				chk("real", din_real, exp_real((k / N) % 3, k % N));
				chk("sop", din_sop, (k % N) == 0);
				k++;
			end
		end
		// slot and ranging figures settle one edge after the take
		@(posedge hclk);
		chk("slot len", {16'h0, slot_len}, 32'h48);
		chk("slot symbols", {16'h0, slot_sym_sum}, 32'h48);
		chk("slot tiles", {16'h0, slot_tile_sum}, 32'hB4);
		chk("rng len", {16'h0, rng_len}, 32'h90);
		chk("rng order", {31'h0, rng_bad}, 32'h0);
		stall <= 1'b0;
		ahb(1'b0, `OTP_A_GRP, 32'h0, d);
		chk("groups", d, 32'h0000_0001);
		$display("test stream done");
	endtask : t_stream

	// one map word taken from the chosen source
	task automatic take(input logic r, output logic [31:0] d);
		do @(posedge hclk);
		while (!(r ? rmap_valid === 1'b1 && rmap_ready === 1'b1
		           : dmap_valid === 1'b1 && dmap_ready === 1'b1));
		d = r ? rmap_data : dmap_data;
	endtask : take

	// new map words are resent on every request
	task automatic t_maps;
		logic [31:0] d, w;
		for (int r = 0; r < 2; r++) begin
			w = r ? 32'h5A3C_F021 : 32'hA5C3_0F12;
			ahb(1'b1, r ? `OTP_A_RMAP : `OTP_A_DMAP, w, d);
			for (int i = 0; i < 4 && d !== w; i++) begin
				take(r[0], d);
			end
			take(r[0], d);
			chk("map first", d, w);
			take(r[0], d);
			chk("map again", d, w);
		end
		$display("test maps done");
	endtask : t_maps

	// print counts and verdict, then stop
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim

	// main sequence
	initial begin
		hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
		haddr = 32'h0; hwdata = 32'h0; htrans = 2'h0; hsize = 3'h2;
		stall = 1'b0; bad_count = 0; cmp_count = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs();
		t_stream();
		t_maps();
		end_sim();
	end

	// watchdog, about four times the expected run
	initial begin
		repeat (25000) @(posedge hclk);
		bad_count++;
		$display("mismatch watchdog expected done seen hang");
		end_sim();
	end
endmodule : tb_top

`default_nettype wire
